// ===== logic/pde_decoder_defs.vh
`ifndef PDE_DECODER_DEFS_VH
`define PDE_DECODER_DEFS_VH

// ****************************************************************
// entry field positions
// ****************************************************************
`define PDE_EXEC_BLOCK_POS 63
`define PDE_IGN_HI_MSB 62
`define PDE_IGN_HI_LSB 52
`define PDE_RSV_MSB 51
`define PDE_ADDR_LSB 12
`define PDE_PSEL_POS 11
`define PDE_EXT_ACCESS_POS 10
`define PDE_RSV7_POS 7
`define PDE_ACC_POS 5
`define PDE_CD_POS 4
`define PDE_WT_POS 3
`define PDE_US_POS 2
`define PDE_RW_POS 1
`define PDE_P_POS 0

// ****************************************************************
// address widths
// ****************************************************************
`define ADDR_WIDTH_CLIENT 6'h27
`define ADDR_WIDTH_SERVER 6'h2E
`define ADDR_WIDTH_MAX 6'h2E

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_ENTRY_LO 8'h04
`define REG_ENTRY_HI 8'h08
`define REG_REQ 8'h0C
`define REG_RESULT 8'h10
`define REG_BASE_LO 8'h14
`define REG_BASE_HI 8'h18
`define REG_WB_LO 8'h1C
`define REG_WB_HI 8'h20
`define REG_IRQ_STAT 8'h24
`define REG_IRQ_MASK 8'h28

// ctrl bits
`define CTRL_EXEC_BLOCK 0
`define CTRL_NEST 1
`define CTRL_FL64K 2
`define CTRL_EXT_ACCESS 3
`define CTRL_SUPER_WP 4
`define CTRL_SERVER 5
`define CTRL_SUPER_CTX 6

// request bits (write to REG_REQ starts a decode)
`define REQ_EXEC 0
`define REQ_WRITE 1
`define REQ_USER 2

// result bits
`define RES_DONE 0
`define RES_FAULT 1
`define RES_NOT_PRESENT 2
`define RES_RSV_ERR 3
`define RES_PAGE64K 4
`define RES_NESTED 5
`define RES_EXEC_OK 6
`define RES_WRITE_OK 7
`define RES_USER_OK 8
`define RES_WB_NEEDED 9
`define RES_CTX_ERR 10
`define RES_MEMTYPE_WB 11

// irq status bits
`define IRQ_DONE 0
`define IRQ_FAULT 1
`define IRQ_WB 2
`define IRQ_BITS 3

`endif

// ===== logic/sticky_bit.v
// one sticky status flag: set wins over a write-one clear
module sticky_bit (
  input wire aclk,
  input wire aresetn,
  input wire set_i,
  input wire clr_i,
  output reg flag_q
);
  always @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
endmodule

// ===== logic/page_directory_entry_decoder.v
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`include "pde_decoder_defs.vh"

// How it works
// R1 - execute denied when execute_block_enable and entry bit 63 are both set
// R2 - bits 62:52, 9:8 and 6 never influence decode or permissions
// R3 - software keeps bits 51 down to width, and bit 7, zero
// R4 - table base is entry bits width-1 down to 12, 4 KB aligned
// R5 - with nested translation, base is flagged as guest physical address
// R6 - with 64 KB pages enabled, bit 11 picks 64 KB or 4 KB
// R7 - with 64 KB pages disabled, table always maps 4 KB pages
// R8 - with extended-access flag enabled, device sets bit 10 after use
// R9 - with extended-access flag disabled, bit 10 neither used nor updated
// R10 - accessed bit 5 is set on first access through the entry
// R11 - table fetches always write-back; bits 4 and 3 ignored for type
// R12 - user requests rejected when bit 2 is zero
// R13 - supervisor translation contexts are refused
// R14 - user writes denied when bit 1 is zero
// R15 - supervisor writes also denied when bit 1 zero and write-protect on
// R16 - entry present only when bit 0 is one
// R17 - host address width is 39 for client, 46 for server
// R18 - not present or reserved bits set aborts with a translation fault
// R19 - flag updates are one atomic 64-bit read-modify-write
module page_directory_entry_decoder (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EVAL = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state_q;
  reg [6:0] ctrl_q;
  reg [63:0] entry_q;
  reg [2:0] req_q;
  reg [11:0] result_q;
  reg [63:0] base_q;
  reg [63:0] wb_q;
  reg [2:0] irq_mask_q;
  wire [2:0] irq_stat;

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  reg [7:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  // single response slot: a second write waits until bready takes the first
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // address and data park independently, so either may arrive first
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_mapped = (awaddr_q == `REG_CTRL) || (awaddr_q == `REG_ENTRY_LO) ||
                   (awaddr_q == `REG_ENTRY_HI) || (awaddr_q == `REG_REQ) ||
                   (awaddr_q == `REG_IRQ_STAT) || (awaddr_q == `REG_IRQ_MASK);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q <= 8'h00;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? 2'b00 : 2'b10;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // byte-lane merge of the held write into a 32-bit old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire wr_ctrl = wr_fire && (awaddr_q == `REG_CTRL);
  wire wr_elo = wr_fire && (awaddr_q == `REG_ENTRY_LO);
  wire wr_ehi = wr_fire && (awaddr_q == `REG_ENTRY_HI);
  wire wr_req = wr_fire && (awaddr_q == `REG_REQ) && wstrb_q[0];
  wire wr_stat = wr_fire && (awaddr_q == `REG_IRQ_STAT) && wstrb_q[0];
  wire wr_mask = wr_fire && (awaddr_q == `REG_IRQ_MASK) && wstrb_q[0];
  wire [31:0] ctrl_wr = merge({25'h0, ctrl_q}, wdata_q, wstrb_q);

  // ****************************************************************
  // context controls and entry fields by name
  // ****************************************************************
  wire execute_block_enable = ctrl_q[`CTRL_EXEC_BLOCK];
  wire nested_translation_enable = ctrl_q[`CTRL_NEST];
  wire first_level_64k_page_enable = ctrl_q[`CTRL_FL64K];
  wire extended_access_flag_enable = ctrl_q[`CTRL_EXT_ACCESS];
  wire supervisor_write_protect_enable = ctrl_q[`CTRL_SUPER_WP];
  wire execute_block_bit = entry_q[`PDE_EXEC_BLOCK_POS];
  wire table_page_size_select = entry_q[`PDE_PSEL_POS];

  // ****************************************************************
  // entry decode (combinational)
  // ****************************************************************
  wire server = ctrl_q[`CTRL_SERVER];
  wire [5:0] addr_width = server ? `ADDR_WIDTH_SERVER : `ADDR_WIDTH_CLIENT; // [R17]
  // every bit from the width upward; one shift keeps both masks in step
  wire [63:0] above_width = {64{1'b1}} << addr_width;
  wire [63:0] below_rsv_top = {{(63-`PDE_RSV_MSB){1'b0}}, {(`PDE_RSV_MSB+1){1'b1}}};

  // reserved: bits 51 down to the width, and bit 7 [R18]
  wire [63:0] rsv_mask = (above_width & below_rsv_top) | (64'h1 << `PDE_RSV7_POS);
  wire rsv_err = |(entry_q & rsv_mask); // [R18]
  wire present = entry_q[`PDE_P_POS]; // [R16]
  wire ctx_err = ctrl_q[`CTRL_SUPER_CTX]; // [R13]
  wire fault = !present || rsv_err || ctx_err; // [R18]

  // base keeps only width-1:12; ignored bits 62:52 are never looked at [R2]
  wire [63:0] addr_mask = ~above_width & ({64{1'b1}} << `PDE_ADDR_LSB);
  wire [63:0] table_base = entry_q & addr_mask; // [R4]

  // bit 11 only counts with 64 KB pages enabled [R6] [R7]
  wire page64k = first_level_64k_page_enable & table_page_size_select;

  wire is_user = req_q[`REQ_USER];
  wire exec_ok = !(execute_block_enable && execute_block_bit); // [R1]
  wire user_ok = !is_user || entry_q[`PDE_US_POS]; // [R12]
  // [R14] [R15]
  wire write_ok = entry_q[`PDE_RW_POS] || (!is_user && !supervisor_write_protect_enable);

  // flags to set: accessed always, extended only when enabled [R8] [R9] [R10]
  wire [63:0] set_bits = (64'h1 << `PDE_ACC_POS) |
                         ({63'h0, extended_access_flag_enable} << `PDE_EXT_ACCESS_POS);
  wire [63:0] updated = entry_q | set_bits; // [R19]
  wire wb_needed = (updated != entry_q);

  // permissions forced low on any fault so no caller can act on them
  wire [11:0] result_d = {
    1'b1,                 // fetch type is always write-back [R11]
    ctx_err,
    !fault && wb_needed,
    !fault && user_ok,
    !fault && write_ok,
    !fault && exec_ok,
    nested_translation_enable, // base is a guest physical address [R5]
    page64k,
    rsv_err,
    !present,
    fault,
    1'b1
  };

  // ****************************************************************
  // control registers and decode sequence
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      ctrl_q <= 7'h00;
      entry_q <= 64'h0000_0000_0000_0000;
      req_q <= 3'h0;
      result_q <= 12'h000;
      base_q <= 64'h0000_0000_0000_0000;
      wb_q <= 64'h0000_0000_0000_0000;
      irq_mask_q <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_wr[6:0];
      if (wr_mask)
        irq_mask_q <= wdata_q[`IRQ_BITS-1:0];
      // entry is frozen while a decode runs
      if (wr_elo && state_q == ST_IDLE)
        entry_q[31:0] <= merge(entry_q[31:0], wdata_q, wstrb_q);
      if (wr_ehi && state_q == ST_IDLE)
        entry_q[63:32] <= merge(entry_q[63:32], wdata_q, wstrb_q);
      // a request while a decode runs is dropped; software waits for done
      case (state_q)
        ST_IDLE:
        begin
          if (wr_req)
          begin
            req_q <= wdata_q[2:0];
            result_q <= 12'h000;
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL:
        begin
          result_q <= result_d;
          base_q <= fault ? 64'h0 : table_base;
          // single 64-bit image written back in one go [R19]
          wb_q <= (!fault && wb_needed) ? updated : entry_q;
          // a faulting entry keeps its image: nothing may mark it as used
          if (!fault)
            entry_q <= updated; // [R10] [R8]
          state_q <= ST_DONE;
        end
        ST_DONE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  wire done_pulse = (state_q == ST_DONE);
  wire [2:0] irq_set = {done_pulse & result_q[`RES_WB_NEEDED],
                        done_pulse & result_q[`RES_FAULT],
                        done_pulse};
  // one flag per event, so clearing one never swallows another's set
  genvar g;
  generate
    for (g = 0; g < `IRQ_BITS; g = g + 1)
    begin : g_irq
      sticky_bit u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_i(irq_set[g]),
        .clr_i(wr_stat & wdata_q[g]),
        .flag_q(irq_stat[g])
      );
    end
  endgenerate

  // level output: stays high until software writes the flag back as one
  assign irq = |(irq_stat & irq_mask_q);

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_mux;
  reg rd_ok;

  // read data registered: it must stand unchanged while rvalid waits
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @*
  begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      `REG_CTRL: rd_mux = {25'h0, ctrl_q};
      `REG_ENTRY_LO: rd_mux = entry_q[31:0];
      `REG_ENTRY_HI: rd_mux = entry_q[63:32];
      `REG_REQ: rd_mux = {29'h0, req_q};
      `REG_RESULT: rd_mux = {20'h0, result_q};
      `REG_BASE_LO: rd_mux = base_q[31:0];
      `REG_BASE_HI: rd_mux = base_q[63:32];
      `REG_WB_LO: rd_mux = wb_q[31:0];
      `REG_WB_HI: rd_mux = wb_q[63:32];
      `REG_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      `REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule

// ===== verification/pde_decoder_chk.sv
// ****************************************************************
// bus handshake checks at the top ports
// ****************************************************************
module pde_decoder_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("write response code illegal");
endmodule

// ===== verification/pde_entry_memory.sv
// ****************************************************************
// one 64-bit entry of the in-memory paging structure
// ****************************************************************
module pde_entry_memory (
  input wire logic aclk,
  input wire logic st,
  input wire logic [63:0] st_val,
  output logic [63:0] ent
);
  timeunit 1ns;
  timeprecision 1ps;
  // whole-word store so flag updates never tear other fields
  always @(posedge aclk)
    if (st)
      ent <= st_val;
endmodule

// ===== verification/page_directory_entry_decoder_tb.sv
`include "pde_decoder_defs.vh"
// ****************************************************************
// bench
// ****************************************************************
module page_directory_entry_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, st = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, wr_resp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [63:0] st_val = 64'h0, ent;
  int mismatches = 0, total_checks = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  page_directory_entry_decoder i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .irq(irq));
  pde_entry_memory i_mem (.aclk(aclk), .st(st), .st_val(st_val), .ent(ent));
  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // ready is held high throughout, so each wait ends at its answer edge
  task wr(input [7:0] a, input [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    wr_resp = bresp;
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    araddr <= a;
    arvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  function logic [11:0] ex(input [7:0] c, input [63:0] e, input [2:0] q);
    logic rsv;
    rsv = e[7] | (|(e[51:39] >> (c[5] ? 7 : 0)));
    if (!e[0] || rsv || c[6])
      return {1'b1, c[6], 4'h0, c[1], c[2] & e[11], rsv, !e[0], 2'b11};
    return {2'b10, !e[5] | (c[3] & !e[10]), !q[2] | e[2], q[2] ? e[1] : (e[1] | !c[4]),
      !(c[0] & e[63]), c[1], c[2] & e[11], 4'h1};
  endfunction
  task dec(input [7:0] c, input [63:0] e, input [2:0] q);
    logic [31:0] d, lo;
    logic [1:0] r;
    logic [11:0] x;
    x = ex(c, e, q);
    wr(`REG_CTRL, {24'h0, c});
    wr(`REG_ENTRY_LO, e[31:0]);
    wr(`REG_ENTRY_HI, e[63:32]);
    wr(`REG_REQ, {29'h0, q});
    repeat (2) @(posedge aclk);
    rd(`REG_RESULT, d, r);
    chk("result", {20'h0, x}, d);
    rd(`REG_BASE_LO, d, r);
    chk("base_lo", x[1] ? 32'h0 : {e[31:12], 12'h0}, d);
    rd(`REG_BASE_HI, d, r);
    chk("base_hi", x[1] ? 32'h0 : e[63:32] & (c[5] ? 32'h3FFF : 32'h7F), d);
    if (!x[1])
    begin
      rd(`REG_WB_LO, lo, r);
      chk("wb_lo", e[31:0] | 32'h20 | (c[3] ? 32'h400 : 32'h0), lo);
      rd(`REG_WB_HI, d, r);
      chk("wb_hi", e[63:32], d);
      st <= 1;
      st_val <= {d, lo};
      @(posedge aclk);
      st <= 0;
    end
  endtask
  logic [31:0] v;
  logic [1:0] rr;
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(`REG_CTRL, v, rr);
    chk("ctrl_reset", 32'h0, v);
    chk("ctrl_resp", 32'h0, {30'h0, rr});
    rd(8'h3C, v, rr);
    chk("unmapped", 32'h2, {30'h0, rr});
    wr(8'h3C, 32'h0);
    chk("wr_unmapped", 32'h2, {30'h0, wr_resp});
    dec(8'h00, 64'h1007, 3'h4);
    @(posedge aclk);
    dec(8'h00, ent, 3'h4);
    dec(8'h01, 64'h80000000_00000027, 3'h1);
    dec(8'h00, 64'h80000000_00000027, 3'h1);
    dec(8'h04, 64'h827, 3'h4);
    dec(8'h00, 64'h827, 3'h4);
    dec(8'h08, 64'h7, 3'h4);
    dec(8'h00, 64'h7, 3'h4);
    dec(8'h00, 64'h7FF00000_00000367, 3'h6);
    dec(8'h00, 64'h3F, 3'h4);
    dec(8'h00, 64'h23, 3'h4);
    dec(8'h00, 64'h25, 3'h6);
    dec(8'h10, 64'h25, 3'h2);
    dec(8'h00, 64'h25, 3'h2);
    dec(8'h02, 64'h2027, 3'h4);
    dec(8'h40, 64'h27, 3'h4);
    dec(8'h00, 64'hA7, 3'h4);
    dec(8'h00, 64'h100_00000027, 3'h4);
    dec(8'h20, 64'h100_00000027, 3'h4);
    wr(`REG_IRQ_STAT, 32'h7);
    chk("wr_okay", 32'h0, {30'h0, wr_resp});
    dec(8'h00, 64'h26, 3'h4);
    @(posedge aclk);
    rd(`REG_IRQ_STAT, v, rr);
    chk("irq_stat", 32'h3, v);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`REG_IRQ_MASK, 32'h2);
    @(posedge aclk);
    chk("irq_raised", 32'h1, {31'h0, irq});
    wr(`REG_IRQ_STAT, 32'h2);
    @(posedge aclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    results();
  end
endmodule
bind page_directory_entry_decoder pde_decoder_chk i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
